// ===== rtl/motion_param_bank.sv
// Parameter bank of a stepper drive: fieldbus-visible settings and their direct effects.
// Assumes requests and status inputs come from logic on MCLK, so none is synchronised.
// Assumes each request is one whole parameter access held for one cycle.

`timescale 1ns/1ps
`default_nettype none

module motion_param_bank #(
  parameter logic [15:0] START_STOP_RST = 16'h0000,
  parameter logic [15:0] CURRENT_RST = 16'h0000,
  parameter logic [31:0] MODE_MASK = motion_param_pkg::MASK_DEF
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire motion_param_pkg::req_t REQ,
  output motion_param_pkg::rsp_t RSP,
  input wire logic [15:0] REF_SPEED,
  input wire logic PROFILE_MODE,
  input wire logic SOFT_STOP,
  input wire logic FAULT_CLASS1,
  input wire logic HOMING_VALID,
  input wire logic USER_MOTOR,
  input wire logic EXPERT_LEVEL,
  input wire logic [2:0][15:0] PRESET_SPEED,
  input wire logic [31:0] ACT_POS,
  input wire logic [31:0] USER_RANGE_MIN,
  input wire logic [31:0] USER_RANGE_MAX,
  output logic [15:0] CLAMPED_SPEED,
  output logic [31:0] ACTIVE_DECEL,
  output logic [31:0] ACTIVE_ACCEL,
  output logic [15:0] START_STOP_SPEED,
  output logic [15:0] MOTOR_SPEED_LIMIT,
  output logic [15:0] NOMINAL_CURRENT,
  output logic POSITIVE_LIMIT_ENABLE,
  output logic NEGATIVE_LIMIT_ENABLE,
  output logic POS_LIMIT_HIT,
  output logic NEG_LIMIT_HIT
);

  import motion_param_pkg::*;

  // ==========================================================
  // Elaboration checks

  // mode mask bits
  // The mode mask may only set bits that name an operating mode
  if ((MODE_MASK & ~MASK_DEF) != 32'h0000_0000) begin : g_bad_mask
    $error("MODE_MASK sets bits with no operating mode");
  end

  // Reset values must lie inside the ranges that writes accept
  if ((CEIL_RST < CEIL_MIN) || (CEIL_RST > CEIL_MAX)) begin : g_bad_ceil
    $error("Ceiling reset value outside its range");
  end
  if ((QSD_RST < QSD_MIN) || (QSD_RST > RAMP_MAX)) begin : g_bad_qsd
    $error("Quick-stop reset value outside its range");
  end
  if ((ACC_RST < ACC_MIN) || (ACC_RST > RAMP_MAX)) begin : g_bad_acc
    $error("Acceleration reset value outside its range");
  end
  if ((DEC_RST < DEC_MIN) || (DEC_RST > RAMP_MAX)) begin : g_bad_dec
    $error("Deceleration reset value outside its range");
  end
  if ((MLIM_RST < MLIM_MIN) || (MLIM_RST > MLIM_MAX)) begin : g_bad_mlim
    $error("Speed limit reset value outside its range");
  end
  if (SEL_RST > SEL_MAX) begin : g_bad_sel
    $error("Limit selector reset value outside its range");
  end

  // The ramp read divides by the scale, and a full 16-bit write must reach the deceleration floor
  if (SYM_SCALE == 32'h0000_0000) begin : g_bad_scale
    $error("Symmetric ramp scale must not be zero");
  end
  if ((32'h0000_ffff * SYM_SCALE) < DEC_MIN) begin : g_bad_reach
    $error("Symmetric ramp can never reach the deceleration floor");
  end

  // ==========================================================
  // Helpers

  // Unsigned inclusive range test, used by every checked write except the limit selector
  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Signed clip to the permissible user range
  function automatic logic outside_user(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    outside_user = ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
  endfunction

  // ==========================================================
  // Storage
  logic [15:0] ceil_ff;
  logic [15:0] sss_ff;
  logic [31:0] qsd_ff;
  logic [31:0] acc_ff;
  logic [31:0] dec_ff;
  logic [15:0] mlim_ff;
  logic [15:0] inom_ff;
  logic [15:0] sel_ff;
  logic [31:0] pos_ff;
  logic [31:0] neg_ff;
  logic [2:0][15:0] spd_ff;
  rsp_t rsp_ff;
  // Motion outputs settle one cycle after their inputs
  logic [15:0] clamp_ff;
  logic [31:0] decel_ff;
  logic pos_hit_ff;
  logic neg_hit_ff;

  // ==========================================================
  // Access decode
  wire logic [15:0] addr = REQ.addr;
  wire logic [31:0] wdata = REQ.wdata;
  wire logic [15:0] w16 = REQ.wdata[15:0];
  wire logic req_go = CLK_EN & REQ.valid;
  wire logic wr_go = req_go & REQ.write;

  // Register hits; 32-bit ones answer only at their base (even) address
  // paired words
  wire logic hit_sym = (addr == ADDR_SYM);
  wire logic hit_sel = (addr == ADDR_SEL);
  wire logic hit_pos = (addr == ADDR_POS);
  wire logic hit_neg = (addr == ADDR_NEG);
  wire logic hit_ceil = (addr == ADDR_CEIL);
  wire logic hit_acc = (addr == ADDR_ACC);
  wire logic hit_dec = (addr == ADDR_DEC);
  wire logic hit_sss = (addr == ADDR_SSS);
  wire logic hit_qsd = (addr == ADDR_QSD);
  wire logic hit_mlim = (addr == ADDR_MLIM);
  wire logic hit_inom = (addr == ADDR_INOM);
  wire logic hit_mask = (addr == ADDR_MASK);

  // Motor speed hits: index 0 is 90 %, 1 is 50 %, 2 is 20 %
  wire logic [2:0] hit_spd;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_spd_hit
      assign hit_spd[gi] = (addr == (ADDR_SPD90 + 16'(2 * gi)));
    end
  endgenerate

  // Any other address, odd halves of 32-bit parameters included, is refused
  wire logic hit_any = hit_sym | hit_sel | hit_pos | hit_neg | hit_ceil | hit_acc | hit_dec
                     | hit_sss | hit_qsd | hit_mlim | hit_inom | hit_mask | (|hit_spd);

  // Expert-only parameters refuse both reads and writes below expert level
  // expert gate
  wire logic expert_reg = hit_mlim | hit_inom | (|hit_spd);
  wire logic locked = expert_reg & ~EXPERT_LEVEL;

  // Symmetric ramp value in per-minute-per-second units
  // tens scaling
  wire logic [31:0] sym_val = {16'h0000, w16} * SYM_SCALE;

  // Write value checks per register
  // joint check
  wire logic ok_sym = in_range(sym_val, ACC_MIN, RAMP_MAX) & in_range(sym_val, DEC_MIN, RAMP_MAX);
  wire logic ok_acc = in_range(wdata, ACC_MIN, RAMP_MAX);
  wire logic ok_dec = in_range(wdata, DEC_MIN, RAMP_MAX);
  wire logic ok_qsd = in_range(wdata, QSD_MIN, RAMP_MAX);
  wire logic ok_ceil = in_range({16'h0000, w16}, {16'h0000, CEIL_MIN}, {16'h0000, CEIL_MAX});
  wire logic ok_mlim = in_range({16'h0000, w16}, {16'h0000, MLIM_MIN}, {16'h0000, MLIM_MAX});
  wire logic ok_sel = (w16 <= SEL_MAX);

  // Writes refused: bad value, read-only target, or motor speeds of a preset motor
  // preset lock
  wire logic wr_bad = (hit_sym & ~ok_sym) | (hit_acc & ~ok_acc) | (hit_dec & ~ok_dec)
                    | (hit_qsd & ~ok_qsd) | (hit_ceil & ~ok_ceil) | (hit_mlim & ~ok_mlim)
                    | (hit_sel & ~ok_sel) | hit_mask | ((|hit_spd) & ~USER_MOTOR);
  // Locked registers refuse reads as well as writes
  wire logic acc_err = ~hit_any | locked | (REQ.write & wr_bad);
  wire logic wr_ok = wr_go & ~acc_err;

  // ==========================================================
  // Soft limit write values
  // A clipped soft limit write is still answered as accepted
  // clip to extreme
  wire logic [31:0] pos_wval = outside_user(wdata, USER_RANGE_MIN, USER_RANGE_MAX)
                               ? USER_RANGE_MAX : wdata;
  wire logic [31:0] neg_wval = outside_user(wdata, USER_RANGE_MIN, USER_RANGE_MAX)
                               ? USER_RANGE_MIN : wdata;

  // ==========================================================
  // Symmetric ramp read value
  // larger, saturated
  wire logic [31:0] ramp_big = (acc_ff > dec_ff) ? acc_ff : dec_ff;
  wire logic [31:0] ramp_q = ramp_big / SYM_SCALE;
  wire logic [15:0] sym_rd = (ramp_q > 32'h0000_ffff) ? 16'hffff : ramp_q[15:0];

  // Read selection; 16-bit values sit in the low half
  wire logic [31:0] rd_val =
      hit_sym ? {16'h0000, sym_rd} :
      hit_sel ? {16'h0000, sel_ff} :
      hit_pos ? pos_ff :
      hit_neg ? neg_ff :
      hit_ceil ? {16'h0000, ceil_ff} :
      hit_acc ? acc_ff :
      hit_dec ? dec_ff :
      hit_sss ? {16'h0000, sss_ff} :
      hit_qsd ? qsd_ff :
      hit_mlim ? {16'h0000, mlim_ff} :
      hit_inom ? {16'h0000, inom_ff} :
      hit_spd[0] ? {16'h0000, spd_ff[0]} :
      hit_spd[1] ? {16'h0000, spd_ff[1]} :
      hit_spd[2] ? {16'h0000, spd_ff[2]} :
      hit_mask ? MODE_MASK :
      32'h0000_0000;

  // ==========================================================
  // Register updates
  // ceiling store
  wire logic [15:0] nxt_ceil = (wr_ok & hit_ceil) ? w16 : ceil_ff;
  wire logic [15:0] nxt_sss = (wr_ok & hit_sss) ? w16 : sss_ff;
  wire logic [31:0] nxt_qsd = (wr_ok & hit_qsd) ? wdata : qsd_ff;
  wire logic [31:0] nxt_acc = (wr_ok & hit_sym) ? sym_val : (wr_ok & hit_acc) ? wdata : acc_ff;
  wire logic [31:0] nxt_dec = (wr_ok & hit_sym) ? sym_val : (wr_ok & hit_dec) ? wdata : dec_ff;
  wire logic [15:0] nxt_mlim = (wr_ok & hit_mlim) ? w16 : mlim_ff;
  wire logic [15:0] nxt_inom = (wr_ok & hit_inom) ? w16 : inom_ff;
  wire logic [15:0] nxt_sel = (wr_ok & hit_sel) ? w16 : sel_ff;
  wire logic [31:0] nxt_pos = (wr_ok & hit_pos) ? pos_wval : pos_ff;
  wire logic [31:0] nxt_neg = (wr_ok & hit_neg) ? neg_wval : neg_ff;

  // Scalar parameter registers
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ceil_ff <= CEIL_RST;
      sss_ff <= START_STOP_RST;
      qsd_ff <= QSD_RST;
      acc_ff <= ACC_RST;
      dec_ff <= DEC_RST;
      mlim_ff <= MLIM_RST;
      inom_ff <= CURRENT_RST;
      sel_ff <= SEL_RST;
      pos_ff <= POS_RST;
      neg_ff <= NEG_RST;
    end else if (CLK_EN) begin
      ceil_ff <= nxt_ceil;
      sss_ff <= nxt_sss;
      qsd_ff <= nxt_qsd;
      acc_ff <= nxt_acc;
      dec_ff <= nxt_dec;
      mlim_ff <= nxt_mlim;
      inom_ff <= nxt_inom;
      sel_ff <= nxt_sel;
      pos_ff <= nxt_pos;
      neg_ff <= nxt_neg;
    end
  end

  // Motor speeds: follow the preset table unless a user motor is chosen
  // A switch to a user motor keeps the last preset values
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_spd
      wire logic [15:0] nxt_spd = ~USER_MOTOR ? PRESET_SPEED[gi]
                                : (wr_ok & hit_spd[gi]) ? w16 : spd_ff[gi];
      always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
          spd_ff[gi] <= 16'h0000;
        end else if (CLK_EN) begin
          spd_ff[gi] <= nxt_spd;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Access answer, one cycle after the request
  // Refusals and writes carry zero data so nothing stale leaks out
  wire rsp_t nxt_rsp = '{ack: req_go,
                         err: req_go & acc_err,
                         rdata: (req_go & ~REQ.write & ~acc_err) ? rd_val : 32'h0000_0000};

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_ff <= '0;
    end else if (CLK_EN) begin
      rsp_ff <= nxt_rsp;
    end
  end

  // ==========================================================
  // Motion effects

  wire logic [15:0] nxt_clamp = (PROFILE_MODE && (REF_SPEED > ceil_ff)) ? ceil_ff : REF_SPEED;
  // Stop or fault switches to the quick-stop ramp at the next edge
  // stop ramp select
  wire logic [31:0] nxt_decel = (SOFT_STOP | FAULT_CLASS1) ? qsd_ff : dec_ff;

  // Limit enables decoded from the selector
  // direction bits
  wire logic pos_en = sel_ff[SEL_POS_BIT];
  wire logic neg_en = sel_ff[SEL_NEG_BIT];
  // Position compares are signed; limits keep their extreme defaults until written
  // homing gate
  wire logic nxt_pos_hit = pos_en & HOMING_VALID & ($signed(ACT_POS) > $signed(pos_ff));
  wire logic nxt_neg_hit = neg_en & HOMING_VALID & ($signed(ACT_POS) < $signed(neg_ff));

  // Registered motion outputs
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      clamp_ff <= 16'h0000;
      decel_ff <= DEC_RST;
      pos_hit_ff <= 1'b0;
      neg_hit_ff <= 1'b0;
    end else if (CLK_EN) begin
      clamp_ff <= nxt_clamp;
      decel_ff <= nxt_decel;
      pos_hit_ff <= nxt_pos_hit;
      neg_hit_ff <= nxt_neg_hit;
    end
  end

  // ==========================================================
  // Outputs
  assign RSP = rsp_ff;
  assign CLAMPED_SPEED = clamp_ff;
  assign ACTIVE_DECEL = decel_ff;
  assign ACTIVE_ACCEL = acc_ff;
  assign START_STOP_SPEED = sss_ff;
  assign MOTOR_SPEED_LIMIT = mlim_ff;
  assign NOMINAL_CURRENT = inom_ff;
  assign POSITIVE_LIMIT_ENABLE = pos_en;
  assign NEGATIVE_LIMIT_ENABLE = neg_en;
  assign POS_LIMIT_HIT = pos_hit_ff;
  assign NEG_LIMIT_HIT = neg_hit_ff;

endmodule // motion_param_bank

`default_nettype wire

// ===== rtl/motion_param_pkg.sv
// Constants and bundled types for the motion parameter bank.
// Assumes one clock domain; the fieldbus front end delivers whole parameter accesses.

package motion_param_pkg;

  // ==========================================================
  // Parameter addresses
  localparam logic [15:0] ADDR_SYM = 16'h0602;
  localparam logic [15:0] ADDR_SEL = 16'h0606;
  localparam logic [15:0] ADDR_POS = 16'h0608;
  localparam logic [15:0] ADDR_NEG = 16'h060a;
  localparam logic [15:0] ADDR_CEIL = 16'h0612;
  localparam logic [15:0] ADDR_ACC = 16'h0614;
  localparam logic [15:0] ADDR_DEC = 16'h0616;
  localparam logic [15:0] ADDR_SSS = 16'h0622;
  localparam logic [15:0] ADDR_QSD = 16'h0624;
  localparam logic [15:0] ADDR_MLIM = 16'h0e08;
  localparam logic [15:0] ADDR_INOM = 16'h0e0c;
  localparam logic [15:0] ADDR_SPD90 = 16'h0e14;
  localparam logic [15:0] ADDR_SPD20 = 16'h0e18;
  localparam logic [15:0] ADDR_MASK = 16'h1b28;

  // ==========================================================
  // Reset values and accepted ranges
  localparam logic [15:0] CEIL_MIN = 16'h003c;
  localparam logic [15:0] CEIL_MAX = 16'h3390;
  localparam logic [15:0] CEIL_RST = 16'h3390;
  localparam logic [31:0] QSD_MIN = 32'h0000_00c8;
  localparam logic [31:0] RAMP_MAX = 32'h002d_c6c0;
  localparam logic [31:0] QSD_RST = 32'h0000_1770;
  localparam logic [31:0] ACC_MIN = 32'h0000_0001;
  localparam logic [31:0] ACC_RST = 32'h0000_0258;
  localparam logic [31:0] DEC_MIN = 32'h0000_00c8;
  localparam logic [31:0] DEC_RST = 32'h0000_02ee;
  localparam logic [31:0] SYM_SCALE = 32'h0000_000a;
  localparam logic [15:0] MLIM_MIN = 16'h0001;
  localparam logic [15:0] MLIM_MAX = 16'h0bb8;
  localparam logic [15:0] MLIM_RST = 16'h0bb8;
  localparam logic [15:0] SEL_MAX = 16'h0003;
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [31:0] POS_RST = 32'h7fff_ffff;
  localparam logic [31:0] NEG_RST = 32'h8000_0000;
  localparam logic [31:0] MASK_DEF = 32'h007f_0025;
  localparam int SEL_POS_BIT = 0;
  localparam int SEL_NEG_BIT = 1;

  // Access request from the fieldbus front end
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } req_t;

  // Answer to an access
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } rsp_t;

endpackage

// ===== testbench/motion_param_bank_sva.sv
// Port-level checker of the parameter bank.
// Assumes one MCLK domain with RST_B asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module motion_param_bank_sva (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire motion_param_pkg::req_t REQ,
  input wire motion_param_pkg::rsp_t RSP,
  input wire logic [15:0] REF_SPEED,
  input wire logic PROFILE_MODE,
  input wire logic HOMING_VALID,
  input wire logic [15:0] CLAMPED_SPEED,
  input wire logic [31:0] ACTIVE_DECEL,
  input wire logic [31:0] ACTIVE_ACCEL,
  input wire logic [15:0] MOTOR_SPEED_LIMIT,
  input wire logic POSITIVE_LIMIT_ENABLE,
  input wire logic NEGATIVE_LIMIT_ENABLE,
  input wire logic POS_LIMIT_HIT,
  input wire logic NEG_LIMIT_HIT
);
  import motion_param_pkg::*;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  // ============================================
  // Handshake, clamp, limit monitor and ranges
  property p_ack; CLK_EN && REQ.valid |=> RSP.ack; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_err; RSP.err |-> RSP.ack && RSP.rdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("refusal carries data");
  property p_clamp; CLK_EN && PROFILE_MODE |=> CLAMPED_SPEED <= $past(REF_SPEED) && CLAMPED_SPEED <= CEIL_MAX
    && (CLAMPED_SPEED == $past(REF_SPEED) || CLAMPED_SPEED >= CEIL_MIN); endproperty
  a_clamp: assert property (p_clamp) else $error("speed not clamped");
  property p_home; CLK_EN && !HOMING_VALID |=> !POS_LIMIT_HIT && !NEG_LIMIT_HIT; endproperty
  a_home: assert property (p_home) else $error("limit hit before homing");
  property p_sel; CLK_EN |=> (!POS_LIMIT_HIT || $past(POSITIVE_LIMIT_ENABLE))
    && (!NEG_LIMIT_HIT || $past(NEGATIVE_LIMIT_ENABLE)); endproperty
  a_sel: assert property (p_sel) else $error("limit hit while disabled");
  property p_qsd; ACTIVE_DECEL inside {[QSD_MIN:RAMP_MAX]}; endproperty
  a_qsd: assert property (p_qsd) else $error("deceleration out of range");
  property p_mlim; MOTOR_SPEED_LIMIT inside {[MLIM_MIN:MLIM_MAX]}; endproperty
  a_mlim: assert property (p_mlim) else $error("speed limit out of range");
  property p_acc; ACTIVE_ACCEL inside {[ACC_MIN:RAMP_MAX]}; endproperty
  a_acc: assert property (p_acc) else $error("acceleration out of range");
  // Main scenarios reached
  c_err: cover property (RSP.err);
  c_clamp: cover property (CLK_EN && PROFILE_MODE && REF_SPEED > CEIL_MAX);
  c_hit: cover property (POS_LIMIT_HIT || NEG_LIMIT_HIT);
endmodule // motion_param_bank_sva
bind motion_param_bank motion_param_bank_sva motion_param_bank_sva_i (.MCLK(MCLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
  .REQ(REQ), .RSP(RSP), .REF_SPEED(REF_SPEED), .PROFILE_MODE(PROFILE_MODE), .HOMING_VALID(HOMING_VALID),
  .CLAMPED_SPEED(CLAMPED_SPEED), .ACTIVE_DECEL(ACTIVE_DECEL), .ACTIVE_ACCEL(ACTIVE_ACCEL),
  .MOTOR_SPEED_LIMIT(MOTOR_SPEED_LIMIT), .POSITIVE_LIMIT_ENABLE(POSITIVE_LIMIT_ENABLE),
  .NEGATIVE_LIMIT_ENABLE(NEGATIVE_LIMIT_ENABLE), .POS_LIMIT_HIT(POS_LIMIT_HIT), .NEG_LIMIT_HIT(NEG_LIMIT_HIT));
`default_nettype wire

// ===== testbench/fieldbus_master.sv
// Fieldbus master model making one whole parameter access at a time.
// Assumes the bank's answer is visible just after the taking edge.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master (
  input wire logic MCLK,
  input wire motion_param_pkg::rsp_t RSP,
  output motion_param_pkg::req_t REQ
);
  import motion_param_pkg::*;
  initial REQ = '{valid: 1'b0, write: 1'b0, addr: 16'hffff, wdata: 32'h5a5a_a5a5};
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic e,
                      output logic [31:0] r);
    @(negedge MCLK);
    REQ = '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge MCLK);
    #1;
    e = RSP.ack ? RSP.err : 1'bx; // Missing answer never matches
    r = RSP.rdata;
    @(negedge MCLK);
    REQ = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d}; // Released bus shows no stale value
  endtask
endmodule // fieldbus_master
`default_nettype wire

// ===== testbench/motion_param_bank_tb.sv
// Self-checking bench of the parameter bank against an integer model.
// Assumes the master model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module motion_param_bank_tb;
  import motion_param_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic mode = 1'b0, stop = 1'b0, fault = 1'b0, homed = 1'b0, user_mtr = 1'b0, expert = 1'b1;
  logic [15:0] speed = 16'h0000;
  logic [2:0][15:0] presets = {16'h0384, 16'h0258, 16'h012c};
  logic [31:0] pos = 32'h0, rmax = 32'h0001_86a0, rmin = 32'hfffe_7960;
  logic [15:0] clamped, ss_speed, mlim, inom;
  logic [31:0] decel, accel;
  logic pos_en, neg_en, pos_hit, neg_hit;
  logic clk_en = 1'b1;
  logic fe;
  logic [31:0] fr;
  req_t req;
  rsp_t rsp;
  int failures = 0;
  int tests_run = 0;
  int seed = 32'h58b8;
  longint m[int];
  int addrs[14] = '{ADDR_SEL, ADDR_POS, ADDR_NEG, ADDR_CEIL, ADDR_ACC, ADDR_DEC, ADDR_SSS, ADDR_QSD, ADDR_MLIM,
    ADDR_INOM, ADDR_SPD90, 16'h0e16, ADDR_SPD20, ADDR_MASK};
  longint rstv[14] = '{SEL_RST, POS_RST, NEG_RST, CEIL_RST, ACC_RST, DEC_RST, 0, QSD_RST, MLIM_RST, 0, 0, 0, 0, MASK_DEF};
  int ba[22] = '{ADDR_CEIL, ADDR_CEIL, ADDR_CEIL, ADDR_CEIL, ADDR_QSD, ADDR_QSD, ADDR_QSD, ADDR_QSD, ADDR_ACC, ADDR_ACC,
    ADDR_DEC, ADDR_MLIM, ADDR_MLIM, ADDR_MLIM, ADDR_SEL, ADDR_SEL, ADDR_SYM, ADDR_SYM, ADDR_SYM, 'h604, 'h609, 'h618};
  longint bv[22] = '{59, 13201, 60, 13200, 199, 3000001, 3000000, 200, 0, 1, 199, 0, 3001, 1, 4, 3, 19, 20, 65535, 1, 1, 1};
  motion_param_bank motion_param_bank_i (.MCLK(mclk), .RST_B(rst_b), .CLK_EN(clk_en), .REQ(req), .RSP(rsp),
    .REF_SPEED(speed), .PROFILE_MODE(mode), .SOFT_STOP(stop), .FAULT_CLASS1(fault), .HOMING_VALID(homed),
    .USER_MOTOR(user_mtr), .EXPERT_LEVEL(expert), .PRESET_SPEED(presets), .ACT_POS(pos), .USER_RANGE_MIN(rmin),
    .USER_RANGE_MAX(rmax), .CLAMPED_SPEED(clamped), .ACTIVE_DECEL(decel), .ACTIVE_ACCEL(accel),
    .START_STOP_SPEED(ss_speed), .MOTOR_SPEED_LIMIT(mlim), .NOMINAL_CURRENT(inom), .POSITIVE_LIMIT_ENABLE(pos_en),
    .NEGATIVE_LIMIT_ENABLE(neg_en), .POS_LIMIT_HIT(pos_hit), .NEG_LIMIT_HIT(neg_hit));
  fieldbus_master fieldbus_master_i (.MCLK(mclk), .RSP(rsp), .REQ(req));
  // ============================================
  // Shared checks and the register model
  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic model_reset();
    m.delete();
    foreach (addrs[i]) m[addrs[i]] = rstv[i];
  endtask
  // One access, predicted from the model, then compared
  task automatic acc(input logic w, input int a, input longint d);
    logic e, ee;
    logic [31:0] r, er;
    logic signed [31:0] sv;
    longint v, mx;
    bit ok, spd;
    spd = a inside {ADDR_SPD90, 16'h0e16, ADDR_SPD20};
    v = a inside {ADDR_POS, ADDR_NEG, ADDR_ACC, ADDR_DEC, ADDR_QSD, ADDR_MASK} ? d & 32'hffff_ffff : d & 16'hffff;
    sv = v[31:0];
    if (spd && !user_mtr) m[a] = presets[(a - ADDR_SPD90) / 2];
    case (a)
      ADDR_CEIL: ok = v >= 60 && v <= 13200;
      ADDR_QSD, ADDR_DEC: ok = v >= 200 && v <= 3000000;
      ADDR_ACC: ok = v >= 1 && v <= 3000000;
      ADDR_SYM: ok = v * 10 >= 200 && v * 10 <= 3000000;
      ADDR_MLIM: ok = v >= 1 && v <= 3000;
      ADDR_SEL: ok = v <= 3;
      default: ok = 1'b1;
    endcase
    ee = !(m.exists(a) || a == ADDR_SYM) || ((spd || a inside {ADDR_MLIM, ADDR_INOM}) && !expert)
      || (w && (a == ADDR_MASK || (spd && !user_mtr) || !ok));
    er = 32'h0;
    mx = m[ADDR_ACC] > m[ADDR_DEC] ? m[ADDR_ACC] : m[ADDR_DEC];
    if (!ee && !w) er = a == ADDR_SYM ? (mx / 10 > 65535 ? 65535 : mx / 10) : m[a];
    else if (!ee && a == ADDR_SYM) begin
      m[ADDR_ACC] = v * 10;
      m[ADDR_DEC] = v * 10;
    end else if (!ee && (a == ADDR_POS || a == ADDR_NEG))
      m[a] = (sv < $signed(rmin) || sv > $signed(rmax)) ? (a == ADDR_POS ? rmax : rmin) : v;
    else if (!ee) m[a] = v;
    fieldbus_master_i.xfer(w, a[15:0], d[31:0], e, r);
    check(e === ee && r === er, "access answer");
    check(accel === 32'(m[ADDR_ACC]) && ss_speed === 16'(m[ADDR_SSS]) && mlim === 16'(m[ADDR_MLIM])
      && inom === 16'(m[ADDR_INOM]) && {neg_en, pos_en} === 2'(m[ADDR_SEL]), "settings");
  endtask
  // Random motion inputs, outputs one cycle later
  task automatic motion(input int n);
    repeat (n) begin
      @(negedge mclk);
      speed = 16'($random(seed));
      {mode, stop, fault, homed} = 4'($random(seed));
      pos = $random(seed) % 2000;
      @(posedge mclk);
      #1;
      check(clamped === (mode && speed > m[ADDR_CEIL] ? 16'(m[ADDR_CEIL]) : speed), "clamp");
      check(decel === 32'(stop || fault ? m[ADDR_QSD] : m[ADDR_DEC]), "decel");
      check(pos_hit === (m[ADDR_SEL][0] && homed && $signed(pos) > $signed(32'(m[ADDR_POS]))), "pos");
      check(neg_hit === (m[ADDR_SEL][1] && homed && $signed(pos) < $signed(32'(m[ADDR_NEG]))), "neg");
    end
  endtask
  task automatic read_all();
    foreach (addrs[i]) acc(1'b0, addrs[i], 0);
    acc(1'b0, ADDR_SYM, 0);
    motion(4);
  endtask
  // ============================================
  // Clock, watchdog and main sequence
  initial forever #50 mclk = ~mclk;
  initial begin
    #500000;
    failures++;
    give_verdict();
  end
  initial begin
    model_reset();
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    read_all();
    $display("test reset values done");
    foreach (ba[i]) begin
      acc(1'b1, ba[i], bv[i]);
      acc(1'b0, ba[i], 0);
    end
    acc(1'b1, ADDR_SSS, $random(seed));
    acc(1'b1, ADDR_ACC, 3000000);
    acc(1'b0, ADDR_SYM, 0);
    acc(1'b1, ADDR_DEC, 5000);
    acc(1'b0, ADDR_SYM, 0);
    $display("test ranges and ramp done");
    @(negedge mclk) expert = 1'b0;
    acc(1'b1, ADDR_INOM, 16'h0123);
    acc(1'b0, ADDR_SPD20, 0);
    @(negedge mclk) expert = 1'b1;
    acc(1'b1, ADDR_INOM, $random(seed));
    for (int a = ADDR_SPD90; a <= ADDR_SPD20; a += 2) acc(1'b1, a, 16'h0100);
    @(negedge mclk) user_mtr = 1'b1;
    for (int a = ADDR_SPD90; a <= ADDR_SPD20; a += 2) begin
      acc(1'b0, a, 0);
      acc(1'b1, a, $random(seed));
    end
    acc(1'b1, ADDR_MASK, 0);
    $display("test access levels done");
    acc(1'b1, ADDR_POS, 200000);
    acc(1'b1, ADDR_NEG, -200000);
    read_all();
    acc(1'b1, ADDR_POS, 1000);
    acc(1'b1, ADDR_NEG, -1000);
    acc(1'b1, ADDR_CEIL, 5000);
    acc(1'b1, ADDR_QSD, 250000);
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, ADDR_SEL, s);
      motion(60);
    end
    // Clock enable low: the bank ignores a write and holds its outputs
    @(negedge mclk);
    clk_en = 1'b0;
    mode = 1'b0;
    speed = ~clamped;
    fieldbus_master_i.xfer(1'b1, ADDR_CEIL, 32'h0000_003c, fe, fr);
    check(rsp.ack === 1'b0 && clamped !== speed, "frozen bank");
    @(negedge mclk);
    clk_en = 1'b1;
    acc(1'b0, ADDR_CEIL, 0);
    motion(2);
    $display("test motion and limits done");
    @(negedge mclk) rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    model_reset();
    rst_b = 1'b1;
    user_mtr = 1'b0;
    read_all();
    $display("test second reset done");
    give_verdict();
  end
endmodule // motion_param_bank_tb
`default_nettype wire
